// ### rtl/smtc_pkg.sv
// constants and types for the secured mode and timer configuration block
// What this block does
// (R01) special functions need read-then-write secured pair
// (R02) frame 0x1300 reads code, low six bits
// (R03) response bits 5:0 hold the random code
// (R04) init entry: 0x52, sel 01, inverted code
// (R05) init entry accepted only in normal mode
// (R06) safe output low only from init mode
// (R07) safe: sel 01, bits 5:4 plain, 3:0 inverted
// (R08) sel 00 reset mode, sel 10 flash
// (R09) flash mode lengthens watchdog up to 32 s
// (R10) timer write: select byte then data byte
// (R11) timer A 7:5 picks overcurrent duration
// (R12) timer A 4:0 picks normal watchdog period
// (R13) timer B 7:4 picks cyclic sense period
// (R14) timer B 3:0 picks cyclic interrupt period
// (R15) timer C 7:4 picks low-power watchdog period
// (R16) timer C 7:4 picks flash watchdog period
// (R17) timer C 3:0 picks forced wake-up period
// (R18) sel 00 reset, 01 init, 10 flash, 11 ignored
// (R19) mismatched code leaves mode and safe unchanged
// (R20) reset loads A 0x1E, B and C zero
package smtc_pkg;

  localparam int          SMTC_FRAME_BITS = 16;
  localparam int          SMTC_CODE_BITS  = 6;

  // first byte decode; bit 8 is the parity slot and is checked only for the code read
  localparam logic [7:0]  SMTC_CMD_RND_HI = 8'h13;
  localparam logic [7:0]  SMTC_CMD_RND_LO = 8'h00;
  localparam logic [6:0]  SMTC_CMD_SPE    = 7'h29;
  localparam logic [6:0]  SMTC_CMD_OVERCURRENT_AND_NORMAL_WATCHDOG_TIMING  = 7'h2A;
  localparam logic [6:0]  SMTC_CMD_CYCLIC_SENSE_AND_INTERRUPT_TIMING  = 7'h2B;
  localparam logic [6:0]  SMTC_CMD_LOW_POWER_WATCHDOG_AND_WAKEUP_TIMING  = 7'h2C;

  localparam logic [1:0]  SMTC_SEL_RESET  = 2'h0;
  localparam logic [1:0]  SMTC_SEL_INIT   = 2'h1;
  localparam logic [1:0]  SMTC_SEL_FLASH  = 2'h2;

  localparam logic [7:0]  SMTC_OVERCURRENT_AND_NORMAL_WATCHDOG_TIMING_RST  = 8'h1E;
  localparam logic [7:0]  SMTC_CYCLIC_SENSE_AND_INTERRUPT_TIMING_RST  = 8'h00;
  localparam logic [7:0]  SMTC_LOW_POWER_WATCHDOG_AND_WAKEUP_TIMING_RST  = 8'h00;

  // arbitrary nonzero seed for the code generator
  localparam logic [15:0] SMTC_LFSR_SEED  = 16'hACE1;

  // field positions
  localparam int          SMTC_HI_SEL_POS = 7;
  localparam int          SMTC_LO_SEL_POS = 3;
  localparam int          SMTC_WDN_BASE_LO = 3;

  // period bases; normal watchdog in half milliseconds
  localparam logic [16:0] SMTC_OVC_B0  = 17'h00003;
  localparam logic [16:0] SMTC_OVC_B1  = 17'h00004;
  localparam logic [16:0] SMTC_WDN_B   = 17'h00005;
  localparam logic [16:0] SMTC_CS_B0   = 17'h00003;
  localparam logic [16:0] SMTC_CS_B1   = 17'h00004;
  localparam logic [16:0] SMTC_CI_B0   = 17'h00006;
  localparam logic [16:0] SMTC_CI_B1   = 17'h00008;
  localparam logic [16:0] SMTC_WDLP_B0 = 17'h0000C;
  localparam logic [16:0] SMTC_WDLP_B1 = 17'h00010;
  localparam logic [16:0] SMTC_WDF_B0  = 17'h00030;
  localparam logic [16:0] SMTC_WDF_B1  = 17'h00100;
  localparam logic [16:0] SMTC_FWU_B0  = 17'h00030;
  localparam logic [16:0] SMTC_FWU_B1  = 17'h00040;

  typedef struct packed {
    logic [7:0] overcurrent_and_normal_watchdog_timing;
    logic [7:0] cyclic_sense_and_interrupt_timing;
    logic [7:0] low_power_watchdog_and_wakeup_timing;
  } smtc_timers_t;

  typedef struct packed {
    logic [16:0] ovc_ms;
    logic [16:0] wd_norm_hms;
    logic [16:0] cyc_sense_ms;
    logic [16:0] cyc_int_ms;
    logic [16:0] wd_lp_ms;
    logic [16:0] wd_flash_ms;
    logic [16:0] fwu_ms;
  } smtc_periods_t;

  typedef struct packed {
    logic go_reset;
    logic go_init;
    logic go_flash;
  } smtc_mode_req_t;

endpackage : smtc_pkg

// ### rtl/smtc_top.sv
// secured special-mode entry and timer configuration over the serial link
`timescale 1ns/1ps
module smtc_top
  import smtc_pkg::*;
(
  // system clock and reset
  input  wire logic           clk_i,
  input  wire logic           reset_n_i,
  // serial link from the host
  input  wire logic           sclk_i,
  input  wire logic           cs_n_i,
  input  wire logic           mosi_i,
  output logic                miso_o,
  // device mode status, same clock domain
  input  wire logic           in_normal_i,
  input  wire logic           in_init_i,
  input  wire logic           in_flash_i,
  // mode requests and safe output
  output smtc_mode_req_t      mode_req_o,
  output logic                safe_low_o,
  // timer configuration
  output smtc_timers_t        timers_o,
  output smtc_periods_t       periods_o,
  output logic [16:0]         wd_period_hms_o
);

  // ---------------- link domain ----------------
  logic                       link_rst_n;
  logic [3:0]                 bit_cnt_reg;
  logic [14:0]                shift_reg;
  logic [15:0]                frame_reg;
  logic                       frame_tgl_reg;
  logic                       miso_reg;
  logic [15:0]                resp_word;
  logic [SMTC_CODE_BITS-1:0]  code_reg;

  // the frame's own select ends the frame; the clock may stop after
  assign link_rst_n = reset_n_i & ~cs_n_i;

  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_reg <= 15'h0000;
    end else begin
      shift_reg <= {shift_reg[13:0], mosi_i};
    end
  end

  // a frame counts only once all sixteen bits are in
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_reg <= 16'h0000;
    end else if (!cs_n_i && bit_cnt_reg == 4'hF) begin
      frame_reg <= {shift_reg, mosi_i}; // R10
    end
  end

  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_tgl_reg <= 1'b0;
    end else if (!cs_n_i && bit_cnt_reg == 4'hF) begin
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // code is held still between reads and only changes a few system
  // clocks after a frame ends, long before the next frame's low bits
  assign resp_word = {{(SMTC_FRAME_BITS - SMTC_CODE_BITS){1'b0}}, code_reg}; // R03

  // msb goes out before the first falling edge; it is always zero
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_reg <= 1'b0;
    end else begin
      miso_reg <= resp_word[~bit_cnt_reg]; // R02
    end
  end

  assign miso_o = miso_reg;

  // ---------------- system domain ----------------
  logic                       tgl_s1_reg;
  logic                       tgl_s2_reg;
  logic                       tgl_s3_reg;
  logic                       frame_evt;
  logic [7:0]                 cmd_byte;
  logic [7:0]                 data_byte;
  logic                       is_rnd_read;
  logic                       is_spe;
  logic [15:0]                lfsr_reg;
  logic [SMTC_CODE_BITS-1:0]  armed_code_reg;
  logic                       armed_reg;
  logic                       code_inv_ok;
  logic                       code_safe_ok;
  logic [1:0]                 sel_mode;
  smtc_timers_t               timers_reg;
  smtc_periods_t              periods_next;
  smtc_periods_t              periods_reg;
  smtc_mode_req_t             mode_req_reg;
  smtc_mode_req_t             mode_req_next;
  logic                       safe_low_reg;
  logic [16:0]                wd_period_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= frame_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // frame_reg stays put for a whole frame after the toggle moves
  assign frame_evt   = tgl_s2_reg ^ tgl_s3_reg;
  assign cmd_byte    = frame_reg[15:8];
  assign data_byte   = frame_reg[7:0];
  assign is_rnd_read = frame_evt && cmd_byte == SMTC_CMD_RND_HI
                       && data_byte == SMTC_CMD_RND_LO; // R02
  assign is_spe      = frame_evt && cmd_byte[7:1] == SMTC_CMD_SPE;
  assign sel_mode    = data_byte[7:6];
  assign code_inv_ok = data_byte[5:0] == ~armed_code_reg; // R04
  assign code_safe_ok = data_byte[5:4] == armed_code_reg[5:4]
                        && data_byte[3:0] == ~armed_code_reg[3:0]; // R07

  // free-running generator; the code is what the host cannot predict
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lfsr_reg <= SMTC_LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // a read arms the code it just sent and draws a fresh one
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_reg <= {SMTC_CODE_BITS{1'b0}};
    end else if (is_rnd_read) begin
      code_reg <= lfsr_reg[SMTC_CODE_BITS-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_code_reg <= {SMTC_CODE_BITS{1'b0}};
    end else if (is_rnd_read) begin
      armed_code_reg <= code_reg; // R01
    end
  end

  // any other frame disarms, so guessing costs a fresh read each time
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_reg <= 1'b0;
    end else if (frame_evt) begin
      armed_reg <= is_rnd_read; // R01
    end
  end

  always_comb begin
    mode_req_next = '0;
    if (is_spe && armed_reg && code_inv_ok) begin // R19
      unique case (sel_mode)
        SMTC_SEL_RESET: mode_req_next.go_reset = 1'b1; // R08
        SMTC_SEL_INIT:  mode_req_next.go_init  = in_normal_i; // R05
        SMTC_SEL_FLASH: mode_req_next.go_flash = 1'b1; // R08
        default:        mode_req_next = '0; // R18
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_req_reg <= '0;
    end else begin
      mode_req_reg <= mode_req_next;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      safe_low_reg <= 1'b0;
    end else if (is_spe && armed_reg && sel_mode == SMTC_SEL_INIT
                 && code_safe_ok && in_init_i) begin // R06 R19
      safe_low_reg <= 1'b1;
    end
  end

  // timer writes need no secured sequence
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timers_reg.overcurrent_and_normal_watchdog_timing <= SMTC_OVERCURRENT_AND_NORMAL_WATCHDOG_TIMING_RST; // R20
      timers_reg.cyclic_sense_and_interrupt_timing <= SMTC_CYCLIC_SENSE_AND_INTERRUPT_TIMING_RST; // R20
      timers_reg.low_power_watchdog_and_wakeup_timing <= SMTC_LOW_POWER_WATCHDOG_AND_WAKEUP_TIMING_RST; // R20
    end else if (frame_evt) begin
      if (cmd_byte[7:1] == SMTC_CMD_OVERCURRENT_AND_NORMAL_WATCHDOG_TIMING) begin
        timers_reg.overcurrent_and_normal_watchdog_timing <= data_byte; // R10
      end
      if (cmd_byte[7:1] == SMTC_CMD_CYCLIC_SENSE_AND_INTERRUPT_TIMING) begin
        timers_reg.cyclic_sense_and_interrupt_timing <= data_byte; // R10
      end
      if (cmd_byte[7:1] == SMTC_CMD_LOW_POWER_WATCHDOG_AND_WAKEUP_TIMING) begin
        timers_reg.low_power_watchdog_and_wakeup_timing <= data_byte; // R10
      end
    end
  end

  // doubling tables: base picked by the high bit, shifted per step
  function automatic logic [16:0] smtc_period(input logic        hi,
                                              input logic [2:0]  step,
                                              input logic [16:0] b0,
                                              input logic [16:0] b1);
    logic [16:0] base;
    base = hi ? b1 : b0;
    return base << step;
  endfunction : smtc_period

  always_comb begin
    periods_next.ovc_ms = smtc_period(timers_reg.overcurrent_and_normal_watchdog_timing[SMTC_HI_SEL_POS],
                                      {1'b0, timers_reg.overcurrent_and_normal_watchdog_timing[6:5]},
                                      SMTC_OVC_B0, SMTC_OVC_B1); // R11
    periods_next.wd_norm_hms =
      (SMTC_WDN_B + {15'h0000, timers_reg.overcurrent_and_normal_watchdog_timing[4:SMTC_WDN_BASE_LO]})
      << timers_reg.overcurrent_and_normal_watchdog_timing[2:0]; // R12
    periods_next.cyc_sense_ms = smtc_period(timers_reg.cyclic_sense_and_interrupt_timing[SMTC_HI_SEL_POS],
                                            timers_reg.cyclic_sense_and_interrupt_timing[6:4],
                                            SMTC_CS_B0, SMTC_CS_B1); // R13
    periods_next.cyc_int_ms = smtc_period(timers_reg.cyclic_sense_and_interrupt_timing[SMTC_LO_SEL_POS],
                                          timers_reg.cyclic_sense_and_interrupt_timing[2:0],
                                          SMTC_CI_B0, SMTC_CI_B1); // R14
    periods_next.wd_lp_ms = smtc_period(timers_reg.low_power_watchdog_and_wakeup_timing[SMTC_HI_SEL_POS],
                                        timers_reg.low_power_watchdog_and_wakeup_timing[6:4],
                                        SMTC_WDLP_B0, SMTC_WDLP_B1); // R15
    periods_next.wd_flash_ms = smtc_period(timers_reg.low_power_watchdog_and_wakeup_timing[SMTC_HI_SEL_POS],
                                           timers_reg.low_power_watchdog_and_wakeup_timing[6:4],
                                           SMTC_WDF_B0, SMTC_WDF_B1); // R16
    periods_next.fwu_ms = smtc_period(timers_reg.low_power_watchdog_and_wakeup_timing[SMTC_LO_SEL_POS],
                                      timers_reg.low_power_watchdog_and_wakeup_timing[2:0],
                                      SMTC_FWU_B0, SMTC_FWU_B1); // R17
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periods_reg <= '0;
    end else begin
      periods_reg <= periods_next;
    end
  end

  // in flash the long table applies; 32768 ms needs the 17th bit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_period_reg <= 17'h00000;
    end else if (in_flash_i) begin
      wd_period_reg <= {periods_reg.wd_flash_ms[15:0], 1'b0}; // R09
    end else begin
      wd_period_reg <= periods_reg.wd_norm_hms;
    end
  end

  assign mode_req_o      = mode_req_reg;
  assign safe_low_o      = safe_low_reg;
  assign timers_o        = timers_reg;
  assign periods_o       = periods_reg;
  assign wd_period_hms_o = wd_period_reg;

endmodule : smtc_top

// ### dv/smtc_sva.sv
// port assertions for the secured mode and timer block
`timescale 1ns/1ps
module smtc_sva
  import smtc_pkg::*;
(
  // clock and reset
  input wire logic           clk_i,
  input wire logic           reset_n_i,
  // mode status and results
  input wire logic           in_normal_i,
  input wire logic           in_init_i,
  input wire logic           in_flash_i,
  input wire smtc_mode_req_t mode_req_o,
  input wire logic           safe_low_o,
  input wire smtc_timers_t   timers_o,
  input wire smtc_periods_t  periods_o,
  input wire logic [16:0]    wd_period_hms_o
);
  wire logic [16:0] ovc_e = (timers_o.overcurrent_and_normal_watchdog_timing[7] ? 17'h4 : 17'h3) << timers_o.overcurrent_and_normal_watchdog_timing[6:5];
  wire logic [16:0] wdn_e = (17'h5 + 17'(timers_o.overcurrent_and_normal_watchdog_timing[4:3])) << timers_o.overcurrent_and_normal_watchdog_timing[2:0];
  // flash period is in ms, active period in half ms
  wire logic [16:0] wd_e = in_flash_i ? {periods_o.wd_flash_ms[15:0], 1'b0}
                                      : periods_o.wd_norm_hms;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req;
    mode_req_o != 3'h0;
  endsequence
  sequence s_upd;
    $changed(timers_o);
  endsequence
  AST_REQ_ONE: assert property ($onehot0(mode_req_o))
    else $error("several mode requests");
  AST_REQ_PULSE: assert property (s_req |=> mode_req_o == 3'h0)
    else $error("mode request too long");
  AST_INIT_NORM: assert property (mode_req_o.go_init |-> $past(in_normal_i))
    else $error("init request outside normal mode");
  AST_SAFE_INIT: assert property ($rose(safe_low_o) |-> $past(in_init_i))
    else $error("safe output outside init mode");
  AST_SAFE_HOLD: assert property (safe_low_o |=> safe_low_o)
    else $error("safe output released");
  AST_OVC: assert property (s_upd |=> periods_o.ovc_ms == ovc_e)
    else $error("overcurrent period wrong");
  AST_WDN: assert property (s_upd |=> periods_o.wd_norm_hms == wdn_e)
    else $error("normal watchdog period wrong");
  AST_WD: assert property ($past(reset_n_i) |-> wd_period_hms_o == $past(wd_e))
    else $error("active watchdog period wrong");
endmodule : smtc_sva
bind smtc_top smtc_sva u_sva (.clk_i, .reset_n_i, .in_normal_i, .in_init_i, .in_flash_i,
  .mode_req_o, .safe_low_o, .timers_o, .periods_o, .wd_period_hms_o);

// ### dv/smtc_host.sv
// host serial master model
`timescale 1ns/1ps
module smtc_host (
  // link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // clock still between frames; released data line toggles so no stale bit
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #1.3 cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = tx[i];
      #15 sclk_o = 1'b1;
      rx[i] = miso_i;
      #15 sclk_o = 1'b0;
    end
    #15 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #20;
  endtask : xfer
endmodule : smtc_host

// ### dv/test_secure_mode_and_timer_config.sv
// self-checking bench for secured mode entry and timer setup
`timescale 1ns/1ps
module test_secure_mode_and_timer_config;
  import smtc_pkg::*;
  logic           clk_i, reset_n_i, sclk, cs_n, mosi, miso, nrm, ini, fls, safe;
  logic           sq = 1'b0;
  logic [16:0]    wdp;
  // state, select, safe, bad code, repeat, expected event
  logic [11:0]    tbl [9] = '{12'h894, 12'h480, 12'h820, 12'h008, 12'h102,
                              12'h180, 12'h8C0, 12'h4E0, 12'h4C1};
  smtc_mode_req_t mreq;
  smtc_timers_t   tim, tm;
  smtc_timers_t   tp = {8'h1E, 16'h0};
  smtc_periods_t  per;
  logic [3:0]     eq [$];
  smtc_timers_t   tq [$];
  int             n_mismatch = 0;
  int             num_checks = 0;

  smtc_host h (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  smtc_top dut (.clk_i, .reset_n_i, .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .in_normal_i(nrm), .in_init_i(ini), .in_flash_i(fls),
    .mode_req_o(mreq), .safe_low_o(safe), .timers_o(tim), .periods_o(per),
    .wd_period_hms_o(wdp));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    num_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  function automatic smtc_periods_t pexp(smtc_timers_t t);
    pexp.ovc_ms       = (t.overcurrent_and_normal_watchdog_timing[7] ? 17'h4 : 17'h3) << t.overcurrent_and_normal_watchdog_timing[6:5];
    pexp.wd_norm_hms  = (17'h5 + 17'(t.overcurrent_and_normal_watchdog_timing[4:3])) << t.overcurrent_and_normal_watchdog_timing[2:0];
    pexp.cyc_sense_ms = (t.cyclic_sense_and_interrupt_timing[7] ? 17'h4 : 17'h3) << t.cyclic_sense_and_interrupt_timing[6:4];
    pexp.cyc_int_ms   = (t.cyclic_sense_and_interrupt_timing[3] ? 17'h8 : 17'h6) << t.cyclic_sense_and_interrupt_timing[2:0];
    pexp.wd_lp_ms     = (t.low_power_watchdog_and_wakeup_timing[7] ? 17'h10 : 17'hC) << t.low_power_watchdog_and_wakeup_timing[6:4];
    pexp.wd_flash_ms  = (t.low_power_watchdog_and_wakeup_timing[7] ? 17'h100 : 17'h30) << t.low_power_watchdog_and_wakeup_timing[6:4];
    pexp.fwu_ms       = (t.low_power_watchdog_and_wakeup_timing[3] ? 17'h40 : 17'h30) << t.low_power_watchdog_and_wakeup_timing[2:0];
  endfunction : pexp

  // results are noted before the frame that causes them
  always @(negedge clk_i) begin
    if ({mreq, safe & ~sq} !== 4'h0)
      chk("event", eq.size() ? eq.pop_front() : 4'h0, {mreq, safe & ~sq});
    if (tim !== tp) chk("timers", tq.size() ? tq.pop_front() : 'x, tim);
    sq = safe;
    tp = tim;
  end

  task automatic rst;
    if (tm !== {8'h1E, 16'h0}) tq.push_back({8'h1E, 16'h0});
    tm = {8'h1E, 16'h0};
    reset_n_i = 1'b0;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("safe", 1'b0, safe);
    chk("wd", 17'h200, wdp);
    chk("per", pexp(tm), per);
  endtask : rst

  task automatic wt(int r, logic [7:0] d);
    logic [15:0]   rx;
    smtc_periods_t p;
    smtc_timers_t  o;
    o = tm;
    tm[23 - 8 * r -: 8] = d;
    if (tm !== o) tq.push_back(tm);
    h.xfer({7'h2A + 7'(r), 1'($urandom), d}, rx);
    repeat (4) @(negedge clk_i);
    p = pexp(tm);
    chk("per", p, per);
    chk("wd", fls ? {p.wd_flash_ms[15:0], 1'b0} : p.wd_norm_hms, wdp);
  endtask : wt

  task automatic sec(logic [1:0] sel, logic sf, logic bad, logic rep, logic [3:0] e);
    logic [15:0] rx;
    logic [7:0]  d;
    h.xfer(16'h1300, rx);
    chk("resp", 10'h0, rx[15:6]);
    d = sf ? {2'b01, rx[5:4], ~rx[3:0]} : {sel, ~rx[5:0]};
    if (e != 4'h0) eq.push_back(e);
    h.xfer({7'h29, 1'($urandom), d ^ 8'(bad)}, rx);
    if (rep) h.xfer({7'h29, 1'b0, d}, rx);
    repeat (6) @(negedge clk_i);
  endtask : sec

  initial begin
    {reset_n_i, nrm, ini, fls} = 4'h0;
    tm = {8'h1E, 16'h0};
    void'($urandom(32'h2F63));
    rst();
    $display("test reset defaults done");
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_i);
      fls = 1'($urandom);
      wt(i % 3, i < 3 ? 8'hFF : 8'($urandom));
    end
    $display("test timer writes done");
    for (int i = 0; i < 9; i++) begin
      @(negedge clk_i);
      {nrm, ini, fls} = tbl[i][11:9] != 3'h0 ? tbl[i][11:9] : 3'($urandom);
      sec(tbl[i][8:7], tbl[i][6], tbl[i][5], tbl[i][4], tbl[i][3:0]);
    end
    $display("test secured sequences done");
    @(negedge clk_i);
    rst();
    chk("left", 0, eq.size() + tq.size());
    $display("test second reset done");
    give_verdict();
  end

  initial begin
    #60000;
    n_mismatch++;
    give_verdict();
  end
endmodule : test_secure_mode_and_timer_config
